// file: hdl/lmd_defines.vh
`ifndef LMD_DEFINES_VH
`define LMD_DEFINES_VH

// Upper three slave address bits; the value is arbitrary.
`define LMD_DEV_CODE     3'h3

// Sensed connection of an address select pin, as two address bits.
`define LMD_SENSE_GND    2'h0
`define LMD_SENSE_VPLUS  2'h1
`define LMD_SENSE_SDA    2'h2
`define LMD_SENSE_SCL    2'h3

// Received data FIFO: flag bit plus one data byte, eight entries.
`define LMD_FIFO_WIDTH   9
`define LMD_FIFO_DEPTH   8

// Bit count of a byte on the serial bus, ack slot excluded.
`define LMD_BYTE_BITS    4'h8

// Display scan geometry.
`define LMD_ROWS         14
`define LMD_COLS         10
`define LMD_DIGIT_ROWS   7
`define LMD_PIXELS       140

// Multiplex clock rising edges per scanned row.
`define LMD_SCAN_DIV     16'h0040
// Multiplex clock rising edges per blink half period.
`define LMD_BLINK_TICKS  24'h07A120

`endif

// file: hdl/lmd_serial_slave.v
// Behaviour
// R01 - Master starts transfers and drives clock.
// R02 - Data pin is input plus open drain.
// R03 - Clock pin is only ever an input.
// R04 - Start, address, command, data bytes, stop.
// R05 - Idle bus has both lines high.
// R06 - Data falling while clock high starts.
// R07 - Data rising while clock high frees bus.
// R08 - One bit per clock, stable while high.
// R09 - Ninth clock carries a low acknowledge.
// R10 - Device acknowledges every byte it receives; the code nacks a data byte when the FIFO is full.
// R11 - Master acknowledges bytes the device sends.
// R12 - Eighth bit: zero writes, one reads.
// R13 - Fixed code plus four sensed select bits.
// R14 - Scan timing comes from multiplex clock pin.
// R15 - Blink phase output is open drain.
// R16 - Font of 104 fixed, 24 loaded characters; the code holds no font and takes the pixels from digit_pixels.
// R17 - Four mono or two bicolour digits supported.
// R18 - Mono rows and columns shared by digit pairs.
// R19 - Bicolour digit uses fourteen rows, ten columns.
// R20 - Rows sink, columns source, conducting together.
// R21 - Stop after command only stores the pointer.
// R22 - First data byte goes to selected register.
// R23 - Foreign address: no acknowledge, ignore rest.
// R24 - Read bytes MSB first, change while clock low.
`timescale 1ns/10ps
`include "lmd_defines.vh"

module lmd_sync
#(
  parameter WIDTH = 1
)
(
  input  wire             core_clk,
  input  wire             nrst,
  input  wire [WIDTH-1:0] pin,
  output reg  [WIDTH-1:0] level
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;
  integer         i;

  // Three stages; a bit takes a new level once stages two and three agree.
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s1    <= {WIDTH{1'b1}};
      s2    <= {WIDTH{1'b1}};
      s3    <= {WIDTH{1'b1}};
      level <= {WIDTH{1'b1}};
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      for (i = 0; i < WIDTH; i = i + 1)
        if (s2[i] == s3[i])
          level[i] <= s3[i];
    end
  end
endmodule

module lmd_fifo
#(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  input  wire             core_clk,
  input  wire             nrst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  // Full and empty come straight from the fill count.
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers wrap at the depth, so the depth need not be a power of two.
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

module lmd_serial_slave
#(
  parameter [2:0]  DEV_CODE    = `LMD_DEV_CODE,
  parameter [15:0] SCAN_DIV    = `LMD_SCAN_DIV,
  parameter [23:0] BLINK_TICKS = `LMD_BLINK_TICKS
)
(
  input  wire                      core_clk,
  input  wire                      nrst,
  input  wire                      scl_in,
  input  wire                      sda_in,
  output wire                      sda_out,
  output reg                       sda_oe_n,
  input  wire                      address_select_pin_low,
  input  wire                      address_select_pin_high,
  output reg  [7:0]                cmd_byte,
  output reg                       cmd_strobe,
  output wire                      rx_valid,
  input  wire                      rx_ready,
  output wire [`LMD_FIFO_WIDTH-1:0] rx_data,
  input  wire [7:0]                tx_data,
  output reg                       tx_take,
  input  wire                      multiplex_clock_input,
  input  wire [`LMD_PIXELS-1:0]    digit_pixels,
  output reg  [`LMD_ROWS-1:0]      row_sink_outputs,
  output reg  [`LMD_COLS-1:0]      column_source_outputs,
  output wire                      blink_out,
  output reg                       blink_oe_n
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_AACK = 3'h2;
  localparam [2:0] S_RX   = 3'h3;
  localparam [2:0] S_DACK = 3'h4;
  localparam [2:0] S_TX   = 3'h5;
  localparam [2:0] S_MACK = 3'h6;

  wire [4:0] lv;
  wire       scl;
  wire       sda;
  wire       ad0;
  wire       ad1;
  wire       mck;
  reg        scl_d;
  reg        sda_d;
  reg        mck_d;
  wire       rise;
  wire       fall;
  wire       start_ev;
  wire       stop_ev;
  reg  [2:0] state;
  reg  [3:0] bits;
  reg  [7:0] shreg;
  reg        rw;
  reg        first_rx;
  reg        first_data;
  reg        ack_ok;
  reg        push;
  reg  [7:0] push_byte;
  reg        push_first;
  wire       fifo_in_ready;
  reg  [3:0] seen_hi;
  reg  [3:0] seen_lo;
  reg  [1:0] diff_sda;
  wire [3:0] own_low;

  // Pins are sampled only; the clock pin is never driven.
  lmd_sync #(.WIDTH(5)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pin      ({multiplex_clock_input, address_select_pin_high,
                address_select_pin_low, sda_in, scl_in}),
    .level    (lv)
  ); // R03 R14

  assign scl = lv[0];
  assign sda = lv[1];
  assign ad0 = lv[2];
  assign ad1 = lv[3];
  assign mck = lv[4];

  // The data pin only ever pulls low; the blink pin likewise.
  assign sda_out   = 1'b0; // R02
  assign blink_out = 1'b0; // R15

  // Bus edges and the start and stop conditions, seen with clock high.
  assign rise     = scl & ~scl_d; // R08
  assign fall     = ~scl & scl_d;
  assign start_ev = scl & scl_d & sda_d & ~sda; // R06
  assign stop_ev  = scl & scl_d & ~sda_d & sda; // R07

  // Decodes one select pin from what it did during the address byte.
  function [1:0] sense;
    input hi;
    input lo;
    input dsda;
    begin
      if (!hi)
        sense = `LMD_SENSE_GND;
      else if (!lo)
        sense = `LMD_SENSE_VPLUS;
      else if (!dsda)
        sense = `LMD_SENSE_SDA;
      else
        sense = `LMD_SENSE_SCL;
    end
  endfunction

  assign own_low = {sense(seen_hi[1], seen_lo[1], diff_sda[1]),
                    sense(seen_hi[0], seen_lo[0], diff_sda[0])}; // R13

  // Received data bytes queue here; a full queue refuses the byte with a nack.
  lmd_fifo #(
    .WIDTH (`LMD_FIFO_WIDTH),
    .DEPTH (`LMD_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({push_first, push_byte}),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // Serial slave sequencer; a stop or a start overrides any state.
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      scl_d      <= 1'b1;
      sda_d      <= 1'b1;
      state      <= S_IDLE;
      bits       <= 4'h0;
      shreg      <= 8'h00;
      rw         <= 1'b0;
      first_rx   <= 1'b0;
      first_data <= 1'b0;
      ack_ok     <= 1'b0;
      sda_oe_n   <= 1'b1;
      cmd_byte   <= 8'h00;
      cmd_strobe <= 1'b0;
      tx_take    <= 1'b0;
      push       <= 1'b0;
      push_byte  <= 8'h00;
      push_first <= 1'b0;
      seen_hi    <= 4'h0;
      seen_lo    <= 4'h0;
      diff_sda   <= 2'h0;
    end
    else
    begin
      scl_d      <= scl;
      sda_d      <= sda;
      cmd_strobe <= 1'b0;
      tx_take    <= 1'b0;
      push       <= 1'b0;
      if (state == S_ADDR)
      begin
        seen_hi  <= seen_hi | {2'h0, ad1, ad0};
        seen_lo  <= seen_lo | {2'h0, ~ad1, ~ad0};
        diff_sda <= diff_sda | {ad1 ^ sda, ad0 ^ sda};
      end
      if (stop_ev)
      begin
        state    <= S_IDLE; // R05 R07 R21
        sda_oe_n <= 1'b1;
      end
      else if (start_ev)
      begin
        state    <= S_ADDR; // R04 R06
        bits     <= 4'h0;
        sda_oe_n <= 1'b1;
        seen_hi  <= 4'h0;
        seen_lo  <= 4'h0;
        diff_sda <= 2'h0;
      end
      else
      begin
        case (state)
          S_IDLE:
            sda_oe_n <= 1'b1;
          S_ADDR:
          begin
            if (rise)
            begin
              shreg <= {shreg[6:0], sda}; // R08
              bits  <= bits + 4'h1;
            end
            else if (fall && bits == `LMD_BYTE_BITS)
            begin
              rw <= shreg[0]; // R12
              if (shreg[7:1] == {DEV_CODE, own_low})
              begin
                state    <= S_AACK; // R13
                sda_oe_n <= 1'b0; // R09 R10
              end
              else
                state <= S_IDLE; // R23
            end
          end
          S_AACK:
            if (fall)
            begin
              bits <= 4'h0;
              if (rw)
              begin
                shreg    <= tx_data;
                tx_take  <= 1'b1;
                sda_oe_n <= tx_data[7]; // R24
                state    <= S_TX;
              end
              else
              begin
                sda_oe_n <= 1'b1;
                first_rx <= 1'b1;
                state    <= S_RX;
              end
            end
          S_RX:
            if (rise)
            begin
              shreg <= {shreg[6:0], sda}; // R08
              bits  <= bits + 4'h1;
            end
            else if (fall && bits == `LMD_BYTE_BITS)
            begin
              first_rx <= 1'b0;
              state    <= S_DACK;
              if (first_rx)
              begin
                cmd_byte   <= shreg; // R21
                cmd_strobe <= 1'b1;
                first_data <= 1'b1;
                ack_ok     <= 1'b1;
                sda_oe_n   <= 1'b0; // R10
              end
              else if (fifo_in_ready)
              begin
                push       <= 1'b1; // R16
                push_byte  <= shreg;
                push_first <= first_data; // R22
                first_data <= 1'b0;
                ack_ok     <= 1'b1;
                sda_oe_n   <= 1'b0; // R10
              end
              else
                ack_ok <= 1'b0;
            end
          S_DACK:
            if (fall)
            begin
              sda_oe_n <= 1'b1;
              bits     <= 4'h0;
              state    <= ack_ok ? S_RX : S_IDLE;
            end
          S_TX:
            if (fall)
            begin
              bits <= bits + 4'h1;
              if (bits == `LMD_BYTE_BITS - 4'h1)
              begin
                sda_oe_n <= 1'b1;
                state    <= S_MACK;
              end
              else
              begin
                shreg    <= {shreg[6:0], 1'b0};
                sda_oe_n <= shreg[6]; // R24
              end
            end
          S_MACK:
            if (rise)
              ack_ok <= ~sda; // R11
            else if (fall)
            begin
              bits <= 4'h0;
              if (ack_ok)
              begin
                shreg    <= tx_data;
                tx_take  <= 1'b1;
                sda_oe_n <= tx_data[7]; // R24
                state    <= S_TX;
              end
              else
                state <= S_IDLE;
            end
          default:
          begin
            state    <= S_IDLE;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  reg  [15:0] scan_cnt;
  reg  [23:0] blink_cnt;
  reg  [3:0]  row;
  reg         blink_phase;
  wire        mtick;
  wire [3:0]  row_in_digit;
  wire [7:0]  pix_base;

  // Scan advances on rising edges of the multiplex clock.
  assign mtick        = mck & ~mck_d; // R14
  assign row_in_digit = (row < 4'h7) ? row : row - 4'h7;
  assign pix_base     = ((row < 4'h7) ? 8'h00 : 8'h46)
                        + {4'h0, row_in_digit} * 8'h05; // R18 R19

  // Rows sink one at a time; columns source the pair sharing that row.
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      mck_d                 <= 1'b1; // Matches the synchroniser preset.
      scan_cnt              <= 16'h0000;
      blink_cnt             <= 24'h000000;
      row                   <= 4'h0;
      blink_phase           <= 1'b0;
      blink_oe_n            <= 1'b1;
      row_sink_outputs      <= {`LMD_ROWS{1'b0}};
      column_source_outputs <= {`LMD_COLS{1'b0}};
    end
    else
    begin
      mck_d      <= mck;
      blink_oe_n <= blink_phase; // R15
      if (mtick)
      begin
        if (blink_cnt == BLINK_TICKS - 24'h1)
        begin
          blink_cnt   <= 24'h000000;
          blink_phase <= ~blink_phase;
        end
        else
          blink_cnt <= blink_cnt + 24'h1;
        if (scan_cnt == SCAN_DIV - 16'h1)
        begin
          scan_cnt <= 16'h0000;
          row      <= (row == `LMD_ROWS - 1) ? 4'h0 : row + 4'h1;
        end
        else
          scan_cnt <= scan_cnt + 16'h1;
      end
      row_sink_outputs <= {{(`LMD_ROWS-1){1'b0}}, 1'b1} << row; // R20
      column_source_outputs <= {digit_pixels[pix_base + 8'h23 +: 5],
                                digit_pixels[pix_base +: 5]}; // R17 R20
    end
  end
endmodule

// file: test/lmd_serial_slave_properties.sv
`timescale 1ns/10ps
`include "lmd_defines.vh"

module lmd_slave_props
#(
  parameter [2:0]  DEV_CODE    = `LMD_DEV_CODE,
  parameter [15:0] SCAN_DIV    = `LMD_SCAN_DIV,
  parameter [23:0] BLINK_TICKS = `LMD_BLINK_TICKS
)
(
  input wire                       core_clk,
  input wire                       nrst,
  input wire                       scl_in,
  input wire                       sda_out,
  input wire                       sda_oe_n,
  input wire [7:0]                 cmd_byte,
  input wire                       cmd_strobe,
  input wire                       rx_valid,
  input wire                       rx_ready,
  input wire [`LMD_FIFO_WIDTH-1:0] rx_data,
  input wire                       tx_take,
  input wire [`LMD_ROWS-1:0]       row_sink_outputs,
  input wire [`LMD_COLS-1:0]       column_source_outputs,
  input wire                       blink_out,
  input wire                       blink_oe_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Bus clock seen high on two samples running.
  sequence s_scl_high;
    scl_in && $past(scl_in);
  endsequence

  // A received word waits while the consumer stalls.
  sequence s_stalled;
    rx_valid && !rx_ready;
  endsequence

  // Open-drain pins only ever pull low, and the data pin is quiet in SCL high.
  a_sda_never_high: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_blink_open_drain: assert property (blink_out == 1'b0)
    else $error("blink pin driven high");
  a_sda_steady_high: assert property (s_scl_high |-> $stable(sda_oe_n))
    else $error("data pin moved while clock high");
  a_rows_one_hot: assert property ($onehot0(row_sink_outputs))
    else $error("more than one row sinks");
  a_cols_need_row: assert property
    (|column_source_outputs |-> |row_sink_outputs)
    else $error("column sources with no row sinking");
  a_cmd_strobed: assert property ($changed(cmd_byte) |-> cmd_strobe)
    else $error("command byte changed without strobe");
  a_take_single: assert property (tx_take |=> !tx_take)
    else $error("send byte taken twice");
  a_fifo_holds: assert property
    (s_stalled |=> rx_valid && $stable(rx_data))
    else $error("stalled word lost or changed");
  a_reset_quiet: assert property ($rose(nrst) |-> sda_oe_n && blink_oe_n
    && !rx_valid && !cmd_strobe && row_sink_outputs == 14'h0)
    else $error("outputs active after reset");
endmodule

bind lmd_serial_slave lmd_slave_props
#(
  .DEV_CODE    (DEV_CODE),
  .SCAN_DIV    (SCAN_DIV),
  .BLINK_TICKS (BLINK_TICKS)
)
u_props
(
  .core_clk (core_clk), .nrst (nrst), .scl_in (scl_in),
  .sda_out (sda_out), .sda_oe_n (sda_oe_n), .cmd_byte (cmd_byte),
  .cmd_strobe (cmd_strobe), .rx_valid (rx_valid), .rx_ready (rx_ready),
  .rx_data (rx_data), .tx_take (tx_take),
  .row_sink_outputs (row_sink_outputs),
  .column_source_outputs (column_source_outputs),
  .blink_out (blink_out), .blink_oe_n (blink_oe_n)
);

// file: test/lmd_bus_master.sv
`timescale 1ns/10ps

module lmd_bus_master
(
  input  wire core_clk,
  input  wire sda,
  output reg  scl,
  output reg  sda_m
);
  // Bus idles with both lines released high and the clock standing still.
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Waits a number of core clock falling edges.
  task tick(input integer n);
    repeat (n) @(negedge core_clk);
  endtask

  // Data falls while the clock is high; also serves as repeated start.
  task start;
    begin
      sda_m = 1'b1;
      tick(5);
      scl = 1'b1;
      tick(6);
      sda_m = 1'b0;
      tick(6);
      scl = 1'b0;
    end
  endtask

  // Data rises while the clock is high, leaving the bus idle.
  task stop;
    begin
      sda_m = 1'b0;
      tick(5);
      scl = 1'b1;
      tick(6);
      sda_m = 1'b1;
      tick(6);
    end
  endtask

  // One bit: 250 ns low, 150 ns high, wire sampled at the end of high.
  task bit_x(input logic b, output logic r);
    begin
      sda_m = b;
      tick(5);
      scl = 1'b1;
      tick(3);
      r = sda;
      scl = 1'b0;
    end
  endtask

  // Byte MSB first, then the ninth clock; a 1 releases the line.
  task xfer(input logic [7:0] d, input logic ack_in,
            output logic [7:0] q, output logic ack);
    integer i;
    begin
      for (i = 7; i >= 0; i--)
        bit_x(d[i], q[i]);
      bit_x(ack_in, ack);
    end
  endtask
endmodule

// file: test/test_lmd_serial_slave.sv
`timescale 1ns/10ps
`include "lmd_defines.vh"

module test_lmd_serial_slave;
  localparam [6:0] ADDR = {`LMD_DEV_CODE, `LMD_SENSE_VPLUS, `LMD_SENSE_GND};
  logic                       core_clk = 1'b0;
  logic                       nrst = 1'b0;
  logic                       rx_ready = 1'b0;
  logic [7:0]                 tx_data = 8'hA5;
  logic                       mux_clk = 1'b0;
  logic                       sel_lo = 1'b0;
  logic                       sel_hi = 1'b1;
  logic                       tie = 1'b0;
  integer                     strobes = 0;
  logic [`LMD_PIXELS-1:0]     pixels = 140'h0;
  integer                     miscompares = 0;
  integer                     samples_checked = 0;
  wire                        scl, sda_m, sda, sda_out, sda_oe_n;
  wire                        cmd_strobe, rx_valid, tx_take;
  wire                        blink_out, blink_oe_n;
  wire [7:0]                  cmd_byte;
  wire [`LMD_FIFO_WIDTH-1:0]  rx_data;
  wire [`LMD_ROWS-1:0]        rows;
  wire [`LMD_COLS-1:0]        cols;

  // Clocks: 20 MHz core, free running 5 MHz multiplex clock.
  always #25 core_clk = ~core_clk;
  always #100 mux_clk = ~mux_clk;

  // Wired-AND data line with pull-up.
  assign sda = sda_m & (sda_oe_n | sda_out);

  // Next byte to send once the current one is taken.
  always @(negedge core_clk)
    if (tx_take)
      tx_data <= tx_data ^ 8'hFF;

  // Counts command strobes, seen while they stand.
  always @(negedge core_clk)
    if (cmd_strobe)
      strobes++;

  lmd_bus_master m (.core_clk (core_clk), .sda (sda), .scl (scl),
                    .sda_m (sda_m));

  lmd_serial_slave #(.SCAN_DIV (16'h0002), .BLINK_TICKS (24'h000004)) uut
  (
    .core_clk (core_clk), .nrst (nrst), .scl_in (scl), .sda_in (sda),
    .sda_out (sda_out), .sda_oe_n (sda_oe_n),
    .address_select_pin_low (tie ? sda : sel_lo),
    .address_select_pin_high (tie ? scl : sel_hi),
    .cmd_byte (cmd_byte), .cmd_strobe (cmd_strobe), .rx_valid (rx_valid),
    .rx_ready (rx_ready), .rx_data (rx_data), .tx_data (tx_data),
    .tx_take (tx_take), .multiplex_clock_input (mux_clk),
    .digit_pixels (pixels), .row_sink_outputs (rows),
    .column_source_outputs (cols), .blink_out (blink_out),
    .blink_oe_n (blink_oe_n)
  );

  // Counts a comparison and reports a mismatch.
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        miscompares++;
        $display("Error %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  // Start plus address byte; returns the ninth-bit level.
  task open_frame(input logic [6:0] a, input logic rd, output logic ack);
    logic [7:0] q;
    begin
      m.start();
      m.xfer({a, rd}, 1'b1, q, ack);
    end
  endtask

  // Command byte followed directly by a stop.
  task test_cmd_only;
    logic       ack;
    logic [7:0] q;
    begin
      open_frame(ADDR, 1'b0, ack);
      chk("address ack", 16'h0, {15'h0, ack});
      m.xfer(8'h4C, 1'b1, q, ack);
      chk("command ack", 16'h0, {15'h0, ack});
      m.stop();
      m.tick(4);
      chk("command byte", 16'h004C, {8'h0, cmd_byte});
      chk("fifo empty", 16'h0, {15'h0, rx_valid});
      chk("command strobes", 16'h1, strobes[15:0]);
      $display("test_cmd_only done");
    end
  endtask

  // Another slave's address is ignored to the stop.
  task test_foreign;
    logic       ack;
    logic [7:0] q;
    begin
      open_frame(ADDR ^ 7'h01, 1'b0, ack);
      chk("foreign ack", 16'h1, {15'h0, ack});
      m.xfer(8'h11, 1'b1, q, ack);
      chk("foreign data ack", 16'h1, {15'h0, ack});
      m.stop();
      chk("command kept", 16'h004C, {8'h0, cmd_byte});
      chk("foreign strobes", 16'h1, strobes[15:0]);
      $display("test_foreign done");
    end
  endtask

  // Select pins tied to the bus lines give the two remaining codes.
  task test_tied;
    logic ack;
    begin
      tie = 1'b1;
      open_frame({`LMD_DEV_CODE, `LMD_SENSE_SCL, `LMD_SENSE_SDA}, 1'b0, ack);
      chk("tied address ack", 16'h0, {15'h0, ack});
      m.stop();
      tie = 1'b0;
      $display("test_tied done");
    end
  endtask

  // Fills the buffer until it refuses, then drains it.
  task test_fill;
    logic       ack;
    logic [7:0] q;
    integer     i;
    begin
      open_frame(ADDR, 1'b0, ack);
      m.xfer(8'h01, 1'b1, q, ack);
      chk("command ack", 16'h0, {15'h0, ack});
      for (i = 0; i < 9; i++)
      begin
        m.xfer(8'h10 + i[7:0], 1'b1, q, ack);
        chk("data ack", {15'h0, i == 8}, {15'h0, ack});
      end
      m.stop();
      rx_ready = 1'b1;
      for (i = 0; i < 8; i++)
      begin
        chk("rx valid", 16'h1, {15'h0, rx_valid});
        chk("rx word", {7'h0, i == 0, 8'h10 + i[7:0]}, {7'h0, rx_data});
        @(negedge core_clk);
      end
      chk("rx drained", 16'h0, {15'h0, rx_valid});
      rx_ready = 1'b0;
      $display("test_fill done");
    end
  endtask

  // Reads two bytes, acking the first and refusing the second.
  task test_read;
    logic       ack;
    logic [7:0] q;
    begin
      open_frame(ADDR, 1'b1, ack);
      chk("read address ack", 16'h0, {15'h0, ack});
      m.xfer(8'hFF, 1'b0, q, ack);
      chk("read byte 0", 16'h00A5, {8'h0, q});
      m.xfer(8'hFF, 1'b1, q, ack);
      chk("read byte 1", 16'h005A, {8'h0, q});
      m.stop();
      $display("test_read done");
    end
  endtask

  // Digit 0 and digit 3 lit; checks row scan, column halves and blink.
  task test_display;
    logic [13:0] seen;
    logic [13:0] prev;
    logic [9:0]  exp;
    logic        b0;
    logic        flip;
    integer      i;
    begin
      pixels = {35'h7FFFFFFFF, 70'h0, 35'h7FFFFFFFF};
      m.tick(200);
      seen = 14'h0;
      prev = rows;
      b0 = blink_oe_n;
      flip = 1'b0;
      for (i = 0; i < 400; i++)
      begin
        @(negedge core_clk);
        if (blink_oe_n !== b0)
          flip = 1'b1;
        if (rows != 14'h0 && rows === prev)
        begin
          seen = seen | rows;
          exp = (rows[6:0] != 7'h0) ? 10'h01F : 10'h3E0;
          chk("columns", {6'h0, exp}, {6'h0, cols});
        end
        prev = rows;
      end
      chk("rows scanned", 16'h3FFF, {2'h0, seen});
      chk("blink toggled", 16'h1, {15'h0, flip});
      $display("test_display done");
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // Main sequence after a ten-cycle reset.
  initial
  begin
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    repeat (6) @(negedge core_clk);
    test_cmd_only;
    test_foreign;
    test_tied;
    test_fill;
    test_read;
    test_display;
    tally_and_finish;
  end

  // Watchdog well beyond the expected run of about 2170 cycles.
  initial
  begin
    #500000;
    miscompares++;
    tally_and_finish;
  end
endmodule
